/* File: hdl/ptm_timer.sv */
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
module ptm_timer
  import ptm_pkg::*;
#(
  parameter int unsigned DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_out,
  output logic timer_out_en,
  output logic compare_a_flag,
  output logic compare_p_flag
);
  // Register state
  logic [7:0] ctrl0_r;
  ptm_ctrl1_t ctrl1_r;
  logic [9:0] cmp_a_r;
  logic [9:0] cmp_p_r;

  // Counting state
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic en_d_r;

  // Pin and flag state
  logic pin_r;
  logic pin_nxt;
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;

  // Bus qualifiers; slave answers with zero wait states
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd_err = 1'b0;

  // Address decode, one wire per register
  wire hit_c0 = paddr == OFF_CTRL0;
  wire hit_c1 = paddr == OFF_CTRL1;
  wire hit_clo = paddr == OFF_CNT_LO;
  wire hit_chi = paddr == OFF_CNT_HI;
  wire hit_alo = paddr == OFF_CMPA_LO;
  wire hit_ahi = paddr == OFF_CMPA_HI;
  wire hit_plo = paddr == OFF_CMPP_LO;
  wire hit_phi = paddr == OFF_CMPP_HI;
  wire hit_flg = paddr == OFF_FLAGS;

  // Any decoded register, counter bytes included
  wire mapped_ctl = hit_c0 | hit_c1 | hit_flg;
  wire mapped_cnt = hit_clo | hit_chi;
  wire mapped_cmp = hit_alo | hit_ahi | hit_plo | hit_phi;
  wire mapped = mapped_ctl | mapped_cnt | mapped_cmp;

  // Handshake is combinational; unmapped access errors
  assign pready = 1'b1;
  assign pslverr = access & (~mapped | rd_err);

  // Write strobes; counter bytes have none, so writes there are dropped
  wire wr_c0 = wr & hit_c0;
  wire wr_c1 = wr & hit_c1;
  wire wr_alo = wr & hit_alo;
  wire wr_ahi = wr & hit_ahi;
  wire wr_plo = wr & hit_plo;
  wire wr_phi = wr & hit_phi;
  wire wr_flg = wr & hit_flg;

  // Control zero fields
  wire enable = ctrl0_r[C0_EN];
  wire paused = ctrl0_r[C0_PAUSE];
  wire [2:0] ck_sel = ctrl0_r[C0_CKSEL +: 3];
  wire en_rise = enable & ~en_d_r;

  // Control one fields; undefined mode code behaves as compare
  wire pwm_mode = ctrl1_r.mode == PTM_MODE_PWM;
  wire tmr_mode = ctrl1_r.mode == PTM_MODE_TMR;
  wire [1:0] pin_fn = ctrl1_r.pin_function_field;
  wire oc_bit = ctrl1_r.output_control_bit;
  wire pol_bit = ctrl1_r.output_polarity_bit;
  wire clr_sel = ctrl1_r.clear_select_bit;

  // Divider limit per clock select; reserved codes use the slowest rate
  logic [7:0] div_lim;
  always_comb begin
    unique case (ck_sel)
      3'd0: div_lim = DIV_SEL0;
      3'd1: div_lim = DIV_SEL1;
      3'd2: div_lim = DIV_SEL2;
      3'd3: div_lim = DIV_SEL3;
      default: div_lim = DIV_SUB;
    endcase
  end

  // Count tick; pause keeps the counter where it is and clears the divider
  wire running = enable & ~paused;
  wire [DIV_W-1:0] div_end = DIV_W'(div_lim - 8'h01);
  wire tick = running & (div_r >= div_end);

  // Divider restarts on each tick and while stopped
  always_comb begin
    div_nxt = div_r + DIV_W'(1);
    if (tick | ~running) begin
      div_nxt = '0;
    end
  end

  // Step target; a match is the counter reaching the compare value
  wire [10:0] cnt_inc = {1'b0, cnt_r} + 11'h001;
  wire a_zero = cmp_a_r == CMP_RST;
  wire p_zero = cmp_p_r == CMP_RST;

  // P of zero means a full 1024 step period
  wire [10:0] period = p_zero ? 11'h400 : {1'b0, cmp_p_r};

  // Comparators; A of zero never matches
  wire match_a = tick & (cnt_inc == {1'b0, cmp_a_r}) & ~a_zero;
  wire match_p = tick & (cnt_inc == period);
  wire ovf = tick & (cnt_r == CNT_MAX);

  // Clear select only counts outside PWM
  wire cclr = clr_sel & ~pwm_mode;

  // Flag sources; P flag suppressed when A clears the counter
  wire set_a = match_a;
  wire set_p = match_p & ~cclr;

  // Clear sources; A of zero with A clearing wraps at 3ff
  wire clear_cnt = cclr ? match_a : match_p;
  wire wrap = ovf & cclr;

  // Counter next value; the clearing step never stores the compare value
  always_comb begin
    cnt_nxt = cnt_r;
    if (en_rise) begin
      cnt_nxt = '0;
    end else if (clear_cnt | wrap) begin
      cnt_nxt = '0;
    end else if (tick) begin
      cnt_nxt = cnt_inc[9:0];
    end
  end

  // PWM duty: counts 0..period-1, active while below A
  wire duty_full = {1'b0, cmp_a_r} >= period;
  wire below_a = cnt_r < cmp_a_r;
  wire pwm_active = duty_full | below_a;

  // Pin function forces a level while counting carries on
  logic pwm_level;
  always_comb begin
    unique case (pin_fn)
      2'b00: pwm_level = 1'b0;
      2'b01: pwm_level = 1'b1;
      default: pwm_level = pwm_active;
    endcase
  end

  // Active level by output-control, then polarity
  wire pwm_pin = (pwm_level ~^ oc_bit) ^ pol_bit;

  // Compare mode pin action on A match only
  always_comb begin
    pin_nxt = pin_r;
    if (en_rise) begin
      pin_nxt = oc_bit;
    end else if (match_a) begin
      unique case (pin_fn)
        2'b01: pin_nxt = 1'b0;
        2'b10: pin_nxt = 1'b1;
        2'b11: pin_nxt = ~pin_r;
        default: pin_nxt = pin_r;
      endcase
    end
  end

  // Pin level; output-control sets the compare-mode start level
  wire cmp_pin = pin_r ^ pol_bit;
  assign timer_out = pwm_mode ? pwm_pin : cmp_pin;

  // Pin is released in timer/counter mode for other use
  assign timer_out_en = enable & ~tmr_mode;

  // Flag outputs straight from flops
  assign compare_a_flag = flag_r[0];
  assign compare_p_flag = flag_r[1];

  // Per-flag next value; a set wins over a same-cycle write-one clear
  wire [1:0] flg_set = {set_p, set_a};
  wire [1:0] flg_clr = wr_flg ? pwdata[1:0] : 2'b00;
  for (genvar g = 0; g < 2; g++) begin : g_flag
    assign flag_nxt[g] = flg_set[g] | (flag_r[g] & ~flg_clr[g]);
  end

  // Sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 2'b00;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // Enable delayed one cycle for edge detection; reset matches idle enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= enable;
    end
  end

  // Compare-mode pin state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // Control zero; low bits unimplemented and read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_r <= CTRL0_RST;
    end else if (wr_c0) begin
      ctrl0_r <= {pwdata[7:3], 3'b000};
    end
  end

  // Control one; reserved bit held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r <= CTRL1_RST;
    end else if (wr_c1) begin
      ctrl1_r <= {pwdata[7:2], 1'b0, pwdata[0]};
    end
  end

  // Compare A bytes, written independently with no latching
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_r <= CMP_RST;
    end else begin
      if (wr_alo) begin
        cmp_a_r[7:0] <= pwdata[7:0];
      end
      if (wr_ahi) begin
        cmp_a_r[9:8] <= pwdata[1:0];
      end
    end
  end

  // Compare P bytes; a torn update may give one odd period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_p_r <= CMP_RST;
    end else begin
      if (wr_plo) begin
        cmp_p_r[7:0] <= pwdata[7:0];
      end
      if (wr_phi) begin
        cmp_p_r[9:8] <= pwdata[1:0];
      end
    end
  end

  // Read words; unused high bits read zero
  wire [31:0] rd_c0 = {24'h000000, ctrl0_r};
  wire [31:0] rd_c1 = {24'h000000, ctrl1_r};
  wire [31:0] rd_clo = {24'h000000, cnt_r[7:0]};
  wire [31:0] rd_chi = {30'h0, cnt_r[9:8]};
  wire [31:0] rd_alo = {24'h000000, cmp_a_r[7:0]};
  wire [31:0] rd_ahi = {30'h0, cmp_a_r[9:8]};
  wire [31:0] rd_plo = {24'h000000, cmp_p_r[7:0]};
  wire [31:0] rd_phi = {30'h0, cmp_p_r[9:8]};
  wire [31:0] rd_flg = {30'h0, flag_r};

  // Read mux; counter bytes are live, so read low then high with care
  always_comb begin
    unique case (paddr)
      OFF_CTRL0: prdata = rd_c0;
      OFF_CTRL1: prdata = rd_c1;
      OFF_CNT_LO: prdata = rd_clo;
      OFF_CNT_HI: prdata = rd_chi;
      OFF_CMPA_LO: prdata = rd_alo;
      OFF_CMPA_HI: prdata = rd_ahi;
      OFF_CMPP_LO: prdata = rd_plo;
      OFF_CMPP_HI: prdata = rd_phi;
      OFF_FLAGS: prdata = rd_flg;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Unused decode kept visible for the error path
  wire unused_ok = mapped_cnt & 1'b0;
  wire [31:0] pad_word = {31'h0, unused_ok};

  // Spare timing note: a flag write and a match in one cycle leave that flag set
  wire both_events = wr_flg & (set_a | set_p);
  wire [1:0] event_mask = {both_events, 1'b0};

  // Debug view of the step period, not routed out
  wire [10:0] period_view = period;
  wire [10:0] step_view = cnt_inc;

endmodule // ptm_timer

/* File: shared/ptm_pkg.sv */
package ptm_pkg;
  localparam int unsigned CNT_W = 10;
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_CMPP_LO = 8'h18;
  localparam logic [7:0] OFF_CMPP_HI = 8'h1c;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  // Control one field positions
  localparam int unsigned C1_MODE = 6;
  localparam int unsigned C1_PINF = 4;
  localparam int unsigned C1_OC = 3;
  localparam int unsigned C1_POL = 2;
  localparam int unsigned C1_CCLR = 0;
  // Control zero field positions
  localparam int unsigned C0_PAUSE = 7;
  localparam int unsigned C0_CKSEL = 4;
  localparam int unsigned C0_EN = 3;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  // Count tick dividers of pclk for each clock select
  localparam logic [7:0] DIV_SEL0 = 8'h04;
  localparam logic [7:0] DIV_SEL1 = 8'h01;
  localparam logic [7:0] DIV_SEL2 = 8'h10;
  localparam logic [7:0] DIV_SEL3 = 8'h40;
  localparam logic [7:0] DIV_SUB = 8'h80;
  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'b00,
    PTM_MODE_UNDEF = 2'b01,
    PTM_MODE_PWM = 2'b10,
    PTM_MODE_TMR = 2'b11
  } ptm_mode_t;
  typedef struct packed {
    ptm_mode_t mode;
    logic [1:0] pin_function_field;
    logic output_control_bit;
    logic output_polarity_bit;
    logic rsvd;
    logic clear_select_bit;
  } ptm_ctrl1_t;
endpackage

/* File: tb/ptm_timer_asserts.sv */
`timescale 1ns/100ps
module ptm_timer_asserts
  import ptm_pkg::*;
#(
  parameter int unsigned DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_out,
  input wire logic timer_out_en,
  input wire logic compare_a_flag,
  input wire logic compare_p_flag
);
  logic [7:0] c1_r;
  logic en_r;
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire [1:0] md = c1_r[7:6];
  // Shadow of the control bits, taken at the same edge as the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_r <= 8'h00;
      en_r <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == OFF_CTRL1) c1_r <= pwdata[7:0];
      if (paddr == OFF_CTRL0) en_r <= pwdata[C0_EN];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cnt_hi_zero: assert property (rd && paddr == OFF_CNT_HI |-> prdata[31:2] == 30'h0)
    else $error("count high byte upper bits set");
  a_cmpa_hi_zero: assert property (rd && paddr == OFF_CMPA_HI |-> prdata[31:2] == 30'h0)
    else $error("compare A high byte upper bits set");
  a_cmpp_hi_zero: assert property (rd && paddr == OFF_CMPP_HI |-> prdata[31:2] == 30'h0)
    else $error("compare P high byte upper bits set");
  a_pin_enable: assert property (timer_out_en == (en_r && md != PTM_MODE_TMR))
    else $error("pin enable wrong for mode");
  a_flag_a_sticks: assert property (compare_a_flag && !(acc && pwrite && paddr == OFF_FLAGS)
    |=> compare_a_flag) else $error("A flag dropped");
  a_no_p_cclr: assert property ($rose(compare_p_flag) |-> !(c1_r[0] && md != PTM_MODE_PWM))
    else $error("P flag raised with A clear");
  a_pin_no_change: assert property (en_r && $past(en_r) && $past(en_r, 2) && md == PTM_MODE_CMP
    && c1_r[5:4] == 2'b00
    && $stable(c1_r) |-> $stable(timer_out)) else $error("pin moved with function zero");
  a_pwm_forced: assert property (en_r && md == PTM_MODE_PWM && c1_r[5:4] == 2'b01 && !c1_r[2]
    |-> timer_out == c1_r[3]) else $error("forced active level wrong");
  cover property (compare_a_flag && compare_p_flag);
  cover property ($rose(timer_out) && md == PTM_MODE_CMP);
  cover property (md == PTM_MODE_PWM && timer_out_en);
endmodule // ptm_timer_asserts

bind ptm_timer ptm_timer_asserts #(.DIV_W(DIV_W)) chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_out, .timer_out_en,
  .compare_a_flag, .compare_p_flag);

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
  import ptm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ev;
  logic [7:0] paddr = 8'h00, c;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, timer_out, timer_out_en, compare_a_flag, compare_p_flag;
  int fails = 0, n_checks = 0, cyc = 0, hi;
  always #5 pclk = ~pclk;
  ptm_timer #(.DIV_W(8)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_out, .timer_out_en, .compare_a_flag, .compare_p_flag);
  // One APB transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rv, exp);
  endtask
  // Stop, load both compares and control, clear flags, then enable at fastest tick
  task automatic cfg(input logic [9:0] a, input logic [9:0] p, input logic [7:0] c1);
    xfer(1'b1, OFF_CTRL0, 8'h10);
    xfer(1'b1, OFF_CMPA_LO, a[7:0]);
    xfer(1'b1, OFF_CMPA_HI, {6'h0, a[9:8]});
    xfer(1'b1, OFF_CMPP_LO, p[7:0]);
    xfer(1'b1, OFF_CMPP_HI, {6'h0, p[9:8]});
    xfer(1'b1, OFF_CTRL1, c1);
    xfer(1'b1, OFF_FLAGS, 8'h03);
    xfer(1'b1, OFF_CTRL0, 8'h18);
  endtask
  task automatic t_regs;
    rdc(OFF_CNT_HI, 32'h0);
    rdc(OFF_CMPA_LO, 32'h0);
    rdc(OFF_CMPP_HI, 32'h0);
    xfer(1'b1, OFF_CMPA_HI, 8'hff);
    rdc(OFF_CMPA_HI, 32'h3);
    xfer(1'b1, OFF_CMPP_LO, 8'ha5);
    rdc(OFF_CMPP_LO, 32'ha5);
    xfer(1'b1, OFF_CNT_LO, 8'h55);
    rdc(OFF_CNT_LO, 32'h0);
    rdc(8'h40, 32'h0);
    chk({31'h0, ev}, 32'h1);
    $display("registers done");
  endtask
  // Each pin function, from its initial level to the level after one A match
  task automatic t_cmp;
    for (int i = 0; i < 4; i++) begin
      c = i == 0 ? 8'h20 : i == 1 ? 8'h18 : i == 2 ? 8'h30 : 8'h00;
      cfg(10'h028, 10'h050, c);
      @(negedge pclk);
      chk({31'h0, timer_out}, {31'h0, c[3]});
      repeat (60) @(posedge pclk);
      chk({30'h0, compare_p_flag, compare_a_flag}, 32'h1);
      chk({31'h0, timer_out}, {31'h0, c[5:4] == 2'b00 ? c[3] : c[5:4] != 2'b01});
    end
    repeat (60) @(posedge pclk);
    chk({30'h0, compare_p_flag, compare_a_flag}, 32'h3);
    rdc(OFF_CMPA_LO, 32'h28);
    xfer(1'b0, OFF_CNT_LO, 8'h00);
    chk({31'h0, rv < 32'h51}, 32'h1);
    $display("compare mode done");
  endtask
  task automatic t_misc;
    cfg(10'h020, 10'h010, 8'h01);
    repeat (200) @(posedge pclk);
    chk({30'h0, compare_p_flag, compare_a_flag}, 32'h1);
    cfg(10'h000, 10'h000, 8'hc0);
    chk({31'h0, timer_out_en}, 32'h0);
    repeat (1100) @(posedge pclk);
    chk({30'h0, compare_p_flag, compare_a_flag}, 32'h2);
    $display("clear and counter mode done");
  endtask
  // Duty measured over whole periods, so phase does not matter
  task automatic t_pwm;
    cfg(10'h002, 10'h008, 8'ha8);
    for (int k = 0; k < 2; k++) begin
      repeat (4) @(posedge pclk);
      hi = 0;
      repeat (64) begin
        @(posedge pclk);
        hi += timer_out;
      end
      chk(hi, k ? 64 : 16);
      xfer(1'b1, OFF_CMPA_LO, 8'h09);
    end
    cfg(10'h002, 10'h008, 8'h98);
    repeat (20) @(posedge pclk);
    chk({29'h0, timer_out, compare_p_flag, compare_a_flag}, 32'h7);
    $display("pwm done");
  endtask
  task automatic conclude;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_cmp;
    t_misc;
    t_pwm;
    conclude;
  end
endmodule // tb
